// file: inc/clkg_pkg.sv
package clkg_pkg;

  // ==========================================================
  // clock rate and time constants
  localparam int CLK_FREQ_MHZ       = 250;
  localparam int LOOP_FREQ_MIN_MHZ  = 8;
  localparam int LOOP_FREQ_MAX_MHZ  = 40;
  localparam int BUS_FREQ_MAX_MHZ   = 20;
  localparam int DCO_ACC_SPAN       = 65536;
  // reference silence that declares the external clock lost
  localparam int LOSS_TIME_NS       = 100_000;
  localparam int LOSS_CYCLES        = LOSS_TIME_NS * CLK_FREQ_MHZ / 1000;

  // ==========================================================
  // mode select field encoding
  localparam logic [1:0] MODE_SELF       = 2'h0;
  localparam logic [1:0] MODE_INT_LOOP   = 2'h1;
  localparam logic [1:0] MODE_EXT_BYPASS = 2'h2;
  localparam logic [1:0] MODE_EXT_LOOP   = 2'h3;

  // ==========================================================
  // loop prescale and tuning
  localparam logic [6:0]  PRESCALE_LOW    = 7'h40;
  localparam logic [6:0]  PRESCALE_HIGH   = 7'h01;
  localparam logic [15:0] FW_MIN          = 16'((LOOP_FREQ_MIN_MHZ * DCO_ACC_SPAN
                                                 + CLK_FREQ_MHZ - 1) / CLK_FREQ_MHZ);
  localparam logic [15:0] FW_MAX          = 16'(LOOP_FREQ_MAX_MHZ * DCO_ACC_SPAN
                                                / CLK_FREQ_MHZ);
  localparam logic [15:0] FW_RESET        = 16'h1000;
  localparam logic [15:0] STEP_FINE       = 16'h0001;
  localparam logic [15:0] STEP_COARSE     = 16'h0010;
  localparam logic [16:0] LOCK_TOL        = 17'h0_0004;
  localparam logic [16:0] COARSE_ERR      = 17'h0_0040;
  localparam logic [3:0]  LOCK_COUNT      = 4'h4;

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    st_off,
    st_self,
    st_int_unlocked,
    st_int_locked,
    st_ext_bypass,
    st_ext_unlocked,
    st_ext_locked
  } clkg_state_t;

  typedef struct packed {
    clkg_state_t state;
    logic [2:0]  ext_sync;
    logic [2:0]  slow_sync;
    logic [2:0]  fast_sync;
    logic [15:0] fw;
    logic [15:0] acc;
    logic [15:0] tick_cnt;
    logic [3:0]  lock_run;
    logic [31:0] ref_tmo;
    logic        ref_valid;
    logic        lost_lock;
    logic        lost_clock;
    logic [6:0]  div_cnt;
    logic        out_clk;
    logic        loop_clk;
    logic [7:0]  trim;
  } clkg_regs_t;

endpackage

// file: src/clkg_clock_generator.sv
`timescale 1ns/10ps

// Notes on behaviour
// - after reset the generator runs at once in self-clocked mode.
// - self-clocked mode runs the oscillator open loop at its filter setting.
// - off mode holds the output clock static; stop request enters it.
// - internal loop mode multiplies internal reference, unlocked then locked state.
// - external bypass mode drives output straight from external reference.
// - external loop mode multiplies external reference, unlocked then locked state.
// - post-loop divider divides by a power of two, one to 128.
// - loop output stays between 8 and 40 MHz, internal or external reference.
// - flags show lock achieved and later loss of lock.
// - external reference is monitored and its validity reported.
// - loss of clock or lock raises reset or interrupt request as configured.
// - oscillator keeps its frequency while the reference is missing.
// - oscillator setting is retained across off mode.
// - output follows the loop oscillator in both unlocked and locked states.
// - an external reference that is not running cannot be selected.
// - fast internal source feeds debug clock; slow source is software trimmable.
// - two crystal ranges, square-wave input, low power or high gain.
// - outputs loop clock, external reference, debug clock, fixed-frequency enable.
// - the free-running slow internal source also clocks the real-time interrupt.
// - mode select 00 self, 01 int loop, 10 ext bypass, 11 ext loop.
// - loop prescale is 64 for low range and 1 for high range with external reference.
module clkg_clock_generator #(
  parameter int LOSS_CYCLES = clkg_pkg::LOSS_CYCLES
) (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // reference pins, asynchronous
  input  wire logic       ext_ref_pin,
  input  wire logic       slow_ref_pin,
  input  wire logic       fast_ref_pin,
  // configuration
  input  wire logic [1:0] mode_select_field,
  input  wire logic       range_high,
  input  wire logic       ext_square_sel,
  input  wire logic       high_gain_select,
  input  wire logic [7:0] loop_mult,
  input  wire logic [2:0] post_div_sel,
  input  wire logic [7:0] trim_register,
  input  wire logic       stop_req,
  input  wire logic       loss_reset_en,
  input  wire logic       flag_clr,
  // clock outputs
  output logic            generator_output_clock,
  output logic            multiplied_loop_clock,
  output logic            external_reference_clock,
  output logic            debug_local_clock,
  output logic            fixed_frequency_enable,
  output logic            rti_clock,
  // oscillator and reference control
  output logic            osc_enable,
  output logic            osc_high_gain,
  output logic            osc_range_high,
  output logic            osc_square_input,
  output logic [7:0]      int_ref_trim,
  // status
  output logic            loop_locked,
  output logic            lost_lock,
  output logic            lost_clock,
  output logic            ext_ref_valid,
  output logic [1:0]      active_mode,
  output logic            gen_off,
  output logic            loss_reset_req,
  output logic            loss_irq_req
);

  // ==========================================================
  // decoding helpers

  // state that a mode request leads to; external modes need a live reference
  function automatic clkg_pkg::clkg_state_t want_state(
    input logic [1:0] mode,
    input logic       valid
  );
    clkg_pkg::clkg_state_t st;
    st = clkg_pkg::st_self;
    unique case (mode)
      clkg_pkg::MODE_SELF:       st = clkg_pkg::st_self;
      clkg_pkg::MODE_INT_LOOP:   st = clkg_pkg::st_int_unlocked;
      clkg_pkg::MODE_EXT_BYPASS: st = valid ? clkg_pkg::st_ext_bypass   : clkg_pkg::st_self;
      clkg_pkg::MODE_EXT_LOOP:   st = valid ? clkg_pkg::st_ext_unlocked : clkg_pkg::st_self;
    endcase
    return st;
  endfunction

  // locked states fold onto their unlocked entry state
  function automatic clkg_pkg::clkg_state_t base_state(input clkg_pkg::clkg_state_t s);
    clkg_pkg::clkg_state_t b;
    b = s;
    if (s == clkg_pkg::st_int_locked)
    begin
      b = clkg_pkg::st_int_unlocked;
    end
    else if (s == clkg_pkg::st_ext_locked)
    begin
      b = clkg_pkg::st_ext_unlocked;
    end
    return b;
  endfunction

  function automatic logic [1:0] mode_of(input clkg_pkg::clkg_state_t s);
    logic [1:0] m;
    m = clkg_pkg::MODE_SELF;
    unique case (s)
      clkg_pkg::st_off,
      clkg_pkg::st_self:         m = clkg_pkg::MODE_SELF;
      clkg_pkg::st_int_unlocked,
      clkg_pkg::st_int_locked:   m = clkg_pkg::MODE_INT_LOOP;
      clkg_pkg::st_ext_bypass:   m = clkg_pkg::MODE_EXT_BYPASS;
      clkg_pkg::st_ext_unlocked,
      clkg_pkg::st_ext_locked:   m = clkg_pkg::MODE_EXT_LOOP;
    endcase
    return m;
  endfunction

  // ==========================================================
  // state registers
  clkg_pkg::clkg_regs_t s_q;
  clkg_pkg::clkg_regs_t s_d;

  // ==========================================================
  // combinational terms
  logic        ext_rise;
  logic        slow_rise;
  logic        ext_used;
  logic        loop_state;
  logic        locked_state;
  logic        dco_tick;
  logic [16:0] acc_sum;
  logic        loop_ref_edge;
  logic [6:0]  prescale;
  logic [15:0] target;
  logic [16:0] err;
  logic [16:0] err_abs;
  logic [15:0] step;
  logic [16:0] fw_up;
  logic [16:0] fw_dn;
  logic        src_tick;
  logic [6:0]  div_mask;
  logic        out_tick;
  logic        ref_lost_now;
  clkg_pkg::clkg_state_t want;

  always_comb
  begin
    s_d = s_q;

    // only the second and third stages are looked at
    s_d.ext_sync  = {s_q.ext_sync[1:0], ext_ref_pin};
    s_d.slow_sync = {s_q.slow_sync[1:0], slow_ref_pin};
    s_d.fast_sync = {s_q.fast_sync[1:0], fast_ref_pin};
    ext_rise      = s_q.ext_sync[1] & ~s_q.ext_sync[2];
    slow_rise     = s_q.slow_sync[1] & ~s_q.slow_sync[2];
    s_d.trim      = trim_register;

    // ========================================================
    // external reference monitor
    ref_lost_now = 1'b0;
    if (ext_rise)
    begin
      s_d.ref_tmo   = '0;
      s_d.ref_valid = 1'b1;
    end
    else if (s_q.ref_tmo >= 32'(LOSS_CYCLES - 1))
    begin
      s_d.ref_valid = 1'b0;
      ref_lost_now  = s_q.ref_valid;
    end
    else
    begin
      s_d.ref_tmo = s_q.ref_tmo + 32'h0000_0001;
    end

    ext_used     = (s_q.state == clkg_pkg::st_ext_bypass)
                 | (s_q.state == clkg_pkg::st_ext_unlocked)
                 | (s_q.state == clkg_pkg::st_ext_locked);
    loop_state   = (base_state(s_q.state) == clkg_pkg::st_int_unlocked)
                 | (base_state(s_q.state) == clkg_pkg::st_ext_unlocked);
    locked_state = (s_q.state == clkg_pkg::st_int_locked)
                 | (s_q.state == clkg_pkg::st_ext_locked);

    // ========================================================
    // controlled oscillator: phase accumulator, frozen when off
    acc_sum  = {1'b0, s_q.acc} + {1'b0, s_q.fw};
    dco_tick = 1'b0;
    if (s_q.state != clkg_pkg::st_off)
    begin
      s_d.acc  = acc_sum[15:0];
      dco_tick = acc_sum[16];
    end
    if (dco_tick)
    begin
      s_d.loop_clk = ~s_q.loop_clk;
    end

    // ========================================================
    // frequency-locked loop
    // internal reference always uses the low-range prescale
    prescale = (ext_used & range_high) ? clkg_pkg::PRESCALE_HIGH
                                       : clkg_pkg::PRESCALE_LOW;
    target   = 16'(loop_mult * prescale);
    // a missing external edge simply stops corrections
    loop_ref_edge = loop_state & (ext_used ? ext_rise : slow_rise);
    err      = {1'b0, s_q.tick_cnt} - {1'b0, target};
    err_abs  = err[16] ? (17'h0_0000 - err) : err;
    step     = (err_abs > clkg_pkg::COARSE_ERR) ? clkg_pkg::STEP_COARSE
                                                : clkg_pkg::STEP_FINE;
    fw_up    = {1'b0, s_q.fw} + {1'b0, step};
    fw_dn    = {1'b0, s_q.fw} - {1'b0, step};

    if (loop_ref_edge)
    begin
      s_d.tick_cnt = dco_tick ? 16'h0001 : 16'h0000;
      if (err[16])
      begin
        s_d.fw = (fw_up > {1'b0, clkg_pkg::FW_MAX}) ? clkg_pkg::FW_MAX : fw_up[15:0];
      end
      else if (err != 17'h0_0000)
      begin
        s_d.fw = (fw_dn[16] || fw_dn < {1'b0, clkg_pkg::FW_MIN}) ? clkg_pkg::FW_MIN
                                                                  : fw_dn[15:0];
      end
      if (err_abs <= clkg_pkg::LOCK_TOL)
      begin
        if (s_q.lock_run != clkg_pkg::LOCK_COUNT)
        begin
          s_d.lock_run = s_q.lock_run + 4'h1;
        end
      end
      else
      begin
        s_d.lock_run = 4'h0;
      end
    end
    else if (dco_tick && s_q.tick_cnt != 16'hffff)
    begin
      s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
    end

    // ========================================================
    // mode sequencing
    want = want_state(mode_select_field, s_q.ref_valid);
    if (stop_req)
    begin
      s_d.state = clkg_pkg::st_off;
    end
    else if (s_q.state == clkg_pkg::st_off)
    begin
      s_d.state    = want;
      s_d.lock_run = 4'h0;
    end
    else if (base_state(s_q.state) != want)
    begin
      // mode change or lost reference; oscillator word is kept
      s_d.state    = want;
      s_d.lock_run = 4'h0;
    end
    else
    begin
      unique case (s_q.state)
        clkg_pkg::st_int_unlocked,
        clkg_pkg::st_ext_unlocked:
        begin
          if (s_d.lock_run == clkg_pkg::LOCK_COUNT)
          begin
            s_d.state = (s_q.state == clkg_pkg::st_int_unlocked) ? clkg_pkg::st_int_locked
                      : clkg_pkg::st_ext_locked;
          end
        end
        clkg_pkg::st_int_locked,
        clkg_pkg::st_ext_locked:
        begin
          if (loop_ref_edge && err_abs > clkg_pkg::LOCK_TOL)
          begin
            s_d.state = base_state(s_q.state);
          end
        end
        default:
        begin
          // self-clocked and bypass hold here; self never corrects the word
          s_d.state = s_q.state;
        end
      endcase
    end

    // ========================================================
    // sticky loss flags; a new event beats a clear in the same cycle
    if (flag_clr)
    begin
      s_d.lost_lock  = 1'b0;
      s_d.lost_clock = 1'b0;
    end
    if (locked_state && !((s_d.state == clkg_pkg::st_int_locked)
                         || (s_d.state == clkg_pkg::st_ext_locked)))
    begin
      s_d.lost_lock = 1'b1;
    end
    if (ref_lost_now && ext_used)
    begin
      s_d.lost_clock = 1'b1;
    end

    // ========================================================
    // post divider on the selected source
    unique case (s_q.state)
      clkg_pkg::st_off:        src_tick = 1'b0;
      clkg_pkg::st_ext_bypass: src_tick = ext_rise;
      default:                 src_tick = dco_tick;
    endcase
    div_mask = 7'((8'h01 << post_div_sel) - 8'h01);
    out_tick = src_tick & ((s_q.div_cnt & div_mask) == div_mask);
    if (src_tick)
    begin
      s_d.div_cnt = s_q.div_cnt + 7'h01;
    end
    if (out_tick)
    begin
      s_d.out_clk = ~s_q.out_clk;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_q       <= '0;
      s_q.state <= clkg_pkg::st_self;
      s_q.fw    <= clkg_pkg::FW_RESET;
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign generator_output_clock   = s_q.out_clk;
  assign multiplied_loop_clock    = s_q.loop_clk;
  assign external_reference_clock = s_q.ext_sync[2];
  assign debug_local_clock        = s_q.fast_sync[2];
  // fixed-frequency clock is only meaningful with a live external reference
  assign fixed_frequency_enable   = ext_used & s_q.ref_valid;
  // runs off the slow internal source whatever the mode
  assign rti_clock                = s_q.slow_sync[2];
  assign osc_enable               = ext_used;
  assign osc_high_gain            = high_gain_select;
  assign osc_range_high           = range_high;
  assign osc_square_input         = ext_square_sel;
  assign int_ref_trim             = s_q.trim;
  assign loop_locked              = locked_state;
  assign lost_lock                = s_q.lost_lock;
  assign lost_clock               = s_q.lost_clock;
  assign ext_ref_valid            = s_q.ref_valid;
  assign active_mode              = mode_of(s_q.state);
  assign gen_off                  = (s_q.state == clkg_pkg::st_off);
  assign loss_reset_req           = loss_reset_en & (s_q.lost_lock | s_q.lost_clock);
  assign loss_irq_req             = ~loss_reset_en & (s_q.lost_lock | s_q.lost_clock);

endmodule

// file: dv/clkg_ext_osc.sv
`timescale 1ns/10ps
// ==========================================================
// external square-wave reference source
module clkg_ext_osc (
  // control
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  // reference pin
  output logic             ext_ref_pin
);
  // a stopped source sits at its last level, as a dead oscillator would
  initial
  begin
    ext_ref_pin = 1'b0;
    #1;
    forever
    begin
      if (run)
      begin
        #(half_ns);
        ext_ref_pin = ~ext_ref_pin;
      end
      else
        @(posedge run);
    end
  end
endmodule

// file: dv/clkg_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// port checker
module clkg_monitor #(
  parameter int LOSS_CYCLES = 2000
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // inputs
  input wire logic       ce,
  input wire logic [1:0] mode_select_field,
  input wire logic       high_gain_select,
  input wire logic [7:0] trim_register,
  input wire logic       stop_req,
  input wire logic       flag_clr,
  input wire logic       loss_reset_en,
  // outputs
  input wire logic       generator_output_clock,
  input wire logic       fixed_frequency_enable,
  input wire logic       osc_enable,
  input wire logic       osc_high_gain,
  input wire logic [7:0] int_ref_trim,
  input wire logic       loop_locked,
  input wire logic       lost_lock,
  input wire logic       lost_clock,
  input wire logic       ext_ref_valid,
  input wire logic [1:0] active_mode,
  input wire logic       gen_off,
  input wire logic       loss_reset_req,
  input wire logic       loss_irq_req
);
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // assertions
  off_holds_a: assert property (
    gen_off && $past(gen_off) |-> $stable(generator_output_clock))
    else $error("output clock moved while off");
  off_entry_a: assert property (stop_req && ce |=> gen_off)
    else $error("stop request did not turn generator off");
  self_select_a: assert property (
    mode_select_field == clkg_pkg::MODE_SELF && !stop_req && ce
    |=> active_mode == clkg_pkg::MODE_SELF && !gen_off)
    else $error("self-clocked request not followed");
  ext_valid_a: assert property (active_mode[1] |-> $past(ext_ref_valid))
    else $error("external mode without a valid reference");
  clock_loss_a: assert property (
    $fell(ext_ref_valid) && $past(active_mode[1]) |-> lost_clock)
    else $error("reference loss not flagged");
  lock_loss_a: assert property (
    $fell(loop_locked) && $stable(active_mode) && !gen_off |=> lost_lock)
    else $error("loss of lock not flagged");
  lost_sticky_a: assert property (lost_lock && !flag_clr && ce |=> lost_lock)
    else $error("lost lock flag dropped without clear");
  loss_route_a: assert property (
    loss_reset_req == ((lost_lock || lost_clock) && loss_reset_en) &&
    loss_irq_req == ((lost_lock || lost_clock) && !loss_reset_en))
    else $error("loss request routed wrongly");
  trim_copy_a: assert property (ce |=> int_ref_trim == $past(trim_register))
    else $error("trim not copied");
  osc_ctrl_a: assert property (
    osc_high_gain == high_gain_select && osc_enable == active_mode[1])
    else $error("oscillator control wrong");
  ffe_mode_a: assert property (
    fixed_frequency_enable == (active_mode[1] && ext_ref_valid))
    else $error("fixed frequency enable wrong");
  locked_mode_a: assert property (loop_locked |-> active_mode[0] && !gen_off)
    else $error("locked outside a loop mode");

  lock_c: cover property ($rose(loop_locked));
  off_c: cover property ($rose(gen_off));
  ref_loss_c: cover property ($fell(ext_ref_valid) && active_mode[1]);
endmodule

bind clkg_clock_generator clkg_monitor #(.LOSS_CYCLES(LOSS_CYCLES)) u_mon (
  .clk(clk), .rst(rst), .ce(ce), .mode_select_field(mode_select_field),
  .high_gain_select(high_gain_select), .trim_register(trim_register),
  .stop_req(stop_req), .flag_clr(flag_clr), .loss_reset_en(loss_reset_en),
  .generator_output_clock(generator_output_clock), .osc_enable(osc_enable),
  .fixed_frequency_enable(fixed_frequency_enable), .osc_high_gain(osc_high_gain),
  .int_ref_trim(int_ref_trim), .loop_locked(loop_locked), .lost_lock(lost_lock),
  .lost_clock(lost_clock), .ext_ref_valid(ext_ref_valid), .active_mode(active_mode),
  .gen_off(gen_off), .loss_reset_req(loss_reset_req), .loss_irq_req(loss_irq_req)
);

// file: dv/clkg_clock_generator_tb_top.sv
`timescale 1ns/10ps
module clkg_clock_generator_tb_top;
  // ==========================================================
  // settings and signals
  localparam int LOSS = 2000;
  // arbitrary stored trim pattern
  localparam logic [7:0] STORED_TRIM = 8'h5a;
  // mode, divider select, cycles between output toggles
  typedef struct {logic [1:0] mode; logic [2:0] div; logic [15:0] gap;} clkg_row_t;
  clkg_row_t rows [10] = '{'{2'h0, 3'h0, 16'h0010}, '{2'h0, 3'h2, 16'h0040},
    '{2'h2, 3'h0, 16'h0014}, '{2'h2, 3'h1, 16'h0028}, '{2'h2, 3'h2, 16'h0050},
    '{2'h2, 3'h3, 16'h00a0}, '{2'h2, 3'h4, 16'h0140}, '{2'h2, 3'h5, 16'h0280},
    '{2'h2, 3'h6, 16'h0500}, '{2'h2, 3'h7, 16'h0a00}};
  logic        clk, rst, ce, slow_ref_pin, fast_ref_pin, ext_ref_pin, ext_run;
  logic [15:0] ext_half, slow_half;
  logic [1:0]  mode_select_field, active_mode;
  logic        range_high, ext_square_sel, high_gain_select, stop_req, loss_reset_en, flag_clr;
  logic [7:0]  loop_mult, trim_register, int_ref_trim;
  logic [2:0]  post_div_sel;
  logic        generator_output_clock, multiplied_loop_clock, external_reference_clock;
  logic        debug_local_clock, fixed_frequency_enable, rti_clock, osc_enable, osc_high_gain;
  logic        osc_range_high, osc_square_input, loop_locked, lost_lock, lost_clock;
  logic        ext_ref_valid, gen_off, loss_reset_req, loss_irq_req, hold, loop_hold;
  logic [2:0]  seen, seen_prev;
  int          n_fail, total_checks, cyc, gap;

  clkg_clock_generator #(.LOSS_CYCLES(LOSS)) uut (
    .clk(clk), .rst(rst), .ce(ce), .ext_ref_pin(ext_ref_pin), .slow_ref_pin(slow_ref_pin),
    .fast_ref_pin(fast_ref_pin), .mode_select_field(mode_select_field),
    .range_high(range_high), .ext_square_sel(ext_square_sel),
    .high_gain_select(high_gain_select), .loop_mult(loop_mult), .post_div_sel(post_div_sel),
    .trim_register(trim_register), .stop_req(stop_req), .loss_reset_en(loss_reset_en),
    .flag_clr(flag_clr), .generator_output_clock(generator_output_clock),
    .multiplied_loop_clock(multiplied_loop_clock),
    .external_reference_clock(external_reference_clock),
    .debug_local_clock(debug_local_clock), .fixed_frequency_enable(fixed_frequency_enable),
    .rti_clock(rti_clock), .osc_enable(osc_enable), .osc_high_gain(osc_high_gain),
    .osc_range_high(osc_range_high), .osc_square_input(osc_square_input),
    .int_ref_trim(int_ref_trim), .loop_locked(loop_locked), .lost_lock(lost_lock),
    .lost_clock(lost_clock), .ext_ref_valid(ext_ref_valid), .active_mode(active_mode),
    .gen_off(gen_off), .loss_reset_req(loss_reset_req), .loss_irq_req(loss_irq_req)
  );
  clkg_ext_osc u_osc (.run(ext_run), .half_ns(ext_half), .ext_ref_pin(ext_ref_pin));

  // ==========================================================
  // clocks, references and watchdog
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // odd-ns offsets keep slow and external reference edges away from clock edges
  initial
  begin
    fast_ref_pin = 1'b0;
    forever #31 fast_ref_pin = ~fast_ref_pin;
  end
  initial
  begin
    slow_ref_pin = 1'b0;
    #3;
    forever #(slow_half) slow_ref_pin = ~slow_ref_pin;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return loop_locked;
      1: return lost_lock;
      default: return ext_ref_valid;
    endcase
  endfunction
  task automatic wait_sig(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  // cycles between two toggles of the output clock, after two to settle
  task automatic gap_of(output int g);
    logic v;
    for (int k = 0; k < 3; k++)
    begin
      v = generator_output_clock;
      g = 0;
      while (generator_output_clock === v && g < 3000)
      begin
        @(negedge clk);
        g++;
      end
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {rst, ce, ext_run, stop_req, flag_clr, loss_reset_en} = 6'h38;
    {range_high, ext_square_sel, high_gain_select} = 3'h1;
    {ext_half, slow_half, mode_select_field} = {16'h0028, 16'h0800, 2'h0};
    {loop_mult, post_div_sel, trim_register} = {8'h01, 3'h0, 8'h00};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    trim_register = STORED_TRIM;
    repeat (2) @(negedge clk);
    check("int_ref_trim", int_ref_trim, STORED_TRIM);
    check("osc_pins", {osc_range_high, osc_square_input, osc_high_gain}, 3'h1);
    foreach (rows[i])
    begin
      mode_select_field = rows[i].mode;
      post_div_sel = rows[i].div;
      repeat (4) @(negedge clk);
      gap_of(gap);
      check("gap", gap, rows[i].gap);
      check("active_mode", active_mode, rows[i].mode);
    end
    mode_select_field = clkg_pkg::MODE_INT_LOOP;
    wait_sig(0, 1'b1, 12000);
    check("int_lock", loop_locked, 1'b1);
    slow_half = 16'h0960;
    wait_sig(1, 1'b1, 6000);
    check("lost_lock", {lost_lock, loop_locked, loss_irq_req}, 3'h5);
    loss_reset_en = 1'b1;
    @(negedge clk);
    check("loss_reset_req", {loss_reset_req, loss_irq_req}, 2'h2);
    flag_clr = 1'b1;
    @(negedge clk);
    flag_clr = 1'b0;
    @(negedge clk);
    check("lost_lock_clr", lost_lock, 1'b0);
    stop_req = 1'b1;
    repeat (2) @(negedge clk);
    check("gen_off", gen_off, 1'b1);
    {hold, loop_hold, seen} = {generator_output_clock, multiplied_loop_clock, 3'h0};
    seen_prev = {rti_clock, debug_local_clock, external_reference_clock};
    repeat (1100)
    begin
      @(negedge clk);
      seen |= seen_prev ^ {rti_clock, debug_local_clock, external_reference_clock};
      seen_prev = {rti_clock, debug_local_clock, external_reference_clock};
    end
    check("off_static", generator_output_clock, hold);
    check("loop_frozen", multiplied_loop_clock, loop_hold);
    check("rti_runs", seen[2], 1'b1);
    check("ref_clocks_run", seen[1:0], 2'h3);
    stop_req = 1'b0;
    repeat (2) @(negedge clk);
    check("resume", {gen_off, active_mode}, {1'b0, clkg_pkg::MODE_INT_LOOP});
    {ext_half, range_high, mode_select_field} = {16'h0800, 1'b0, clkg_pkg::MODE_EXT_LOOP};
    wait_sig(0, 1'b1, 12000);
    check("ext_lock", {loop_locked, active_mode}, 3'h7);
    {range_high, ext_square_sel} = 2'h3;
    wait_sig(0, 1'b0, 6000);
    repeat (2) @(negedge clk);
    check("high_range", {loop_locked, lost_lock, osc_range_high, osc_square_input}, 4'h7);
    ext_run = 1'b0;
    wait_sig(2, 1'b0, LOSS + 3000);
    @(negedge clk);
    check("ref_loss", {ext_ref_valid, lost_clock, active_mode}, 4'h4);
    ext_run = 1'b1;
    wait_sig(2, 1'b1, 3000);
    repeat (3) @(negedge clk);
    check("ref_back", {active_mode, fixed_frequency_enable}, 3'h7);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check("reset", {active_mode, gen_off, lost_lock, lost_clock, loop_locked}, 6'h00);
    rst = 1'b0;
    report_and_stop();
  end
endmodule
